// ### bench/discharge_pg_delay_config_tb.sv
// Self-checking bench for the discharge and power-good delay bank.
// Assumes short delay parameters; a behavioural model gives expectations.
`timescale 1ns/1ps
module discharge_pg_delay_config_tb
    import dpdc_pkg::*;
;
    localparam int DL [8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    logic                   core_clk;
    logic                   sys_rst;
    dpdc_reg_req_s          reg_req;
    logic [7:0]             reg_rdata;
    logic [RAIL_N-1:0]      rail_enable;
    logic                   rails_reg_pin;
    logic                   level_in_pin;
    dpdc_o3_mode_e          o3_mode;
    logic                   o3_ctrl_level;
    logic                   o3_vtt_use;
    logic [RAIL_N-1:0][2:0] discharge_path;
    logic                   general_output_three;
    logic                   vtt_ldo_enable;
    int n_mismatch, check_count, seed, code, n, base;
    int fld [RAIL_N];

    dpdc_host_model host (.core_clk(core_clk), .req(reg_req));
    dpdc_top #(.DLY0(DL[0]), .DLY1(DL[1]), .DLY2(DL[2]), .DLY3(DL[3]),
        .DLY4(DL[4]), .DLY5(DL[5]), .DLY6(DL[6]), .DLY7(DL[7])) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .rail_enable(rail_enable),
        .rails_reg_pin(rails_reg_pin), .level_in_pin(level_in_pin),
        .o3_mode(o3_mode), .o3_ctrl_level(o3_ctrl_level),
        .o3_vtt_use(o3_vtt_use), .discharge_path(discharge_path),
        .general_output_three(general_output_three),
        .vtt_ldo_enable(vtt_ldo_enable));

    // ************************************************************
    // Clock, checks and model
    // ************************************************************
    always #50 core_clk = ~core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Model image of a register; reserved bits always zero
    function automatic logic [7:0] reg_exp(input int a);
        logic [7:0] v;
        v = '0;
        for (int i = 0; i < 4; i++)
            if (a == 'h41) v[2*i+:2] = fld[i][1:0];
        for (int i = 4; i < 7; i++)
            if (a == 'h42) v[2*(i-4)+:2] = fld[i][1:0];
        if (a == 'h43) v = 8'(code);
        return v;
    endfunction
    // Enabled rails hold their field at 00 in the model too
    task automatic wr(input int a, input logic [7:0] d);
        host.acc(8'(a), d, 1'b1);
        for (int i = 0; i < 7; i++) begin
            if (a == 'h41 && i < 4) fld[i] = d[2*i+:2];
            if (a == 'h42 && i > 3) fld[i] = d[2*(i-4)+:2];
            if (rail_enable[i]) fld[i] = 0;
        end
        if (a == 'h43) code = d[2:0];
    endtask
    task automatic rd_chk(input int a);
        host.acc(8'(a), 8'h00, 1'b0);
        #1 check(reg_rdata, reg_exp(a));
    endtask
    task automatic path_chk;
        repeat (2) @(posedge core_clk);
        #1;
        for (int i = 0; i < 7; i++)
            check(discharge_path[i], fld[i] == 0 ? 0 : 1 << (fld[i]-1));
    endtask
    // Bounded wait for pin (sel 0) or termination enable (sel 1)
    task automatic wt(input int sel, input logic v, output int k);
        k = 0;
        while ((sel ? vtt_ldo_enable : general_output_three) !== v) begin
            @(posedge core_clk);
            #1 k++;
            if (k > 300) begin
                n_mismatch++;
                conclude();
            end
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        core_clk = 0; sys_rst = 1; rail_enable = '0; rails_reg_pin = 0;
        level_in_pin = 0; o3_mode = O3_MODE_PG; o3_ctrl_level = 0;
        o3_vtt_use = 0; code = 0; seed = 45681; fld = '{default: 0};
        n_mismatch = 0; check_count = 0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 0;
        // Reset image and an unmapped address on either side
        foreach (DL[k]) if (k < 5) rd_chk('h40 + (k + 1) % 5);
        // Every code in every field, reserved bits set on the last pass
        for (int k = 0; k < 4; k++) begin
            wr('h41, 8'(8'h55 * k));
            wr('h42, 8'(8'h55 * k));
            path_chk();
            rd_chk('h41);
            rd_chk('h42);
        end
        // Random enables override fields, old and freshly written
        repeat (16) begin
            @(posedge core_clk) rail_enable <= 7'($random(seed));
            #1 foreach (fld[i]) if (rail_enable[i]) fld[i] = 0;
            wr('h41, 8'($random(seed)));
            wr('h42, 8'($random(seed)));
            path_chk();
            rd_chk('h41);
            rd_chk('h42);
        end
        @(posedge core_clk) rail_enable <= '0;
        // Each delay code, upper bits written as ones
        for (int c = 0; c < 8; c++) begin
            wr('h43, 8'hf8 | 8'(c));
            rd_chk('h43);
            @(posedge core_clk) rails_reg_pin <= 1;
            wt(0, 1'b1, n);
            if (c == 0) base = n;
            check(base >= DL[0] + 3 && base <= DL[0] + 9, 1);
            check(n - base, DL[c] - DL[0]);
            @(posedge core_clk) rails_reg_pin <= 0;
            wt(0, 1'b0, n);
            check(n <= 8, 1);
        end
        // Level shifter waits for its input as well as the rails
        @(posedge core_clk) o3_mode <= O3_MODE_LS;
        rails_reg_pin <= 1;
        repeat (40) @(posedge core_clk);
        #1 check(general_output_three, 0);
        @(posedge core_clk) level_in_pin <= 1;
        wt(0, 1'b1, n);
        check(n - base, DL[7] - DL[0]);
        // Software control ignores the delay entirely
        @(posedge core_clk) o3_mode <= O3_MODE_CTRL;
        for (int v = 1; v < 4; v++) begin
            @(posedge core_clk) o3_ctrl_level <= v[0];
            repeat (3) @(posedge core_clk);
            #1 check(general_output_three, v[0]);
            check(vtt_ldo_enable, 0);
        end
        // Software control feeding the termination LDO keeps the delay
        @(posedge core_clk) rails_reg_pin <= 0;
        repeat (10) @(posedge core_clk);
        o3_vtt_use <= 1;
        rails_reg_pin <= 1;
        wt(1, 1'b1, n);
        check(n - base, DL[7] - DL[0]);
        // Mid-run reset clears fields, delay code and both outputs
        @(posedge core_clk) sys_rst <= 1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 0;
        #1 check(vtt_ldo_enable, 0);
        check(general_output_three, 0);
        fld = '{default: 0};
        code = 0;
        rd_chk('h41);
        rd_chk('h43);
        // Unused mode code drives the pin low
        @(posedge core_clk) o3_mode <= dpdc_o3_mode_e'(2'h3);
        repeat (3) @(posedge core_clk);
        #1 check(general_output_three, 0);
        conclude();
    end
endmodule // discharge_pg_delay_config_tb

// ### bench/dpdc_host_model.sv
// Host-side model that issues register writes and reads on the strobe port.
// Assumes the bench calls acc from one process at a time.
`timescale 1ns/1ps
module dpdc_host_model
    import dpdc_pkg::*;
(
    input  wire logic    core_clk, // Core clock
    output dpdc_reg_req_s req      // Request to the bank
);
    // ************************************************************
    // Access task
    // ************************************************************
    initial req = '0;
    // One-cycle strobe, then the released lines show inverted junk so
    // a design that samples late never sees the old value by luck
    task automatic acc(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge core_clk);
        req <= '{a, d, w, !w};
        @(posedge core_clk);
        req <= '{~a, ~d, 1'b0, 1'b0};
    endtask
endmodule // dpdc_host_model

// ### rtl/dpdc_pg_timer.sv
// Power-good delay counter for the third general output.
// Assumes start is synchronous to core_clk and target is stable-ish.
`timescale 1ns/1ps
module dpdc_pg_timer
    import dpdc_pkg::*;
(
    input  wire logic             core_clk, // Core clock
    input  wire logic             sys_rst,  // Async reset, high
    input  wire logic             start,    // Condition met, level
    input  wire logic [CNT_W-1:0] target,   // Delay in cycles
    output logic                  done      // Delay expired, level
);

    logic [CNT_W-1:0] cnt;

    // ************************************************************
    // Count while condition holds; any drop restarts from zero
    // ************************************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt  <= '0;
            done <= 1'b0;
        end else if (!start) begin
            cnt  <= '0;
            done <= 1'b0;
        end else begin
            if (cnt < target) begin
                cnt <= cnt + 1'b1;
            end
            done <= (cnt >= target);
        end
    end

endmodule // dpdc_pg_timer

// ### rtl/dpdc_pkg.sv
// Package for the discharge and power-good delay configuration bank.
// Assumes a single 10 MHz core clock and an 8-bit register access port.
package dpdc_pkg;

    // ************************************************************
    // Register offsets, widths and reset values
    // ************************************************************
    localparam logic [7:0] OFS_DIS_GRP2  = 8'h41;
    localparam logic [7:0] OFS_DIS_GRP3  = 8'h42;
    localparam logic [7:0] OFS_PG_DLY1   = 8'h43;
    localparam int         RAIL_N        = 7;
    localparam int         FIELD_W       = 2;
    localparam int         DLY_W         = 3;
    localparam int         CNT_W         = 20;
    localparam int         GRP2_FIELDS   = 4;
    localparam int         GRP3_LSB      = 8;
    localparam int         GRP3_W        = 6;
    localparam logic [13:0] DIS_RST      = 14'h0000;
    localparam logic [2:0]  DLY_RST      = 3'h0;
    localparam logic [1:0]  DIS_NONE     = 2'h0;

    // Rail index = field index; field i sits at bits 2i+1:2i
    localparam int RAIL_BUCK_FIVE     = 0;
    localparam int RAIL_BUCK_SIX      = 1;
    localparam int RAIL_SWITCH_A_ONE  = 2;
    localparam int RAIL_AUX_LDO_TWO   = 3;
    localparam int RAIL_AUX_LDO_THREE = 4;
    localparam int RAIL_SWITCH_B_ONE  = 5;
    localparam int RAIL_SWITCH_B_TWO  = 6;

    // ************************************************************
    // Timing: delay figures in microseconds, clock in kHz
    // ************************************************************
    localparam longint CLK_KHZ  = 10000;
    localparam longint DLY_US_0 = 2500;
    localparam longint DLY_US_1 = 5000;
    localparam longint DLY_US_2 = 10000;
    localparam longint DLY_US_3 = 15000;
    localparam longint DLY_US_4 = 20000;
    localparam longint DLY_US_5 = 50000;
    localparam longint DLY_US_6 = 75000;
    localparam longint DLY_US_7 = 100000;
    localparam int unsigned DLY_CYC_0 = int'(DLY_US_0 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_1 = int'(DLY_US_1 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_2 = int'(DLY_US_2 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_3 = int'(DLY_US_3 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_4 = int'(DLY_US_4 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_5 = int'(DLY_US_5 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_6 = int'(DLY_US_6 * CLK_KHZ / 1000);
    localparam int unsigned DLY_CYC_7 = int'(DLY_US_7 * CLK_KHZ / 1000);

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        O3_MODE_PG   = 2'h0,
        O3_MODE_LS   = 2'h1,
        O3_MODE_CTRL = 2'h2
    } dpdc_o3_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dpdc_reg_req_s;

endpackage : dpdc_pkg

// ### rtl/dpdc_top.sv
// Discharge select and power-good delay configuration bank.
// Assumes rail enables come from logic on core_clk; regulation and
// level-shifter inputs arrive from pins and are synchronised here.
`timescale 1ns/1ps
module dpdc_top
    import dpdc_pkg::*;
#(
    parameter int unsigned DLY0 = DLY_CYC_0, // 2.5 ms in cycles
    parameter int unsigned DLY1 = DLY_CYC_1, // 5 ms
    parameter int unsigned DLY2 = DLY_CYC_2, // 10 ms
    parameter int unsigned DLY3 = DLY_CYC_3, // 15 ms
    parameter int unsigned DLY4 = DLY_CYC_4, // 20 ms
    parameter int unsigned DLY5 = DLY_CYC_5, // 50 ms
    parameter int unsigned DLY6 = DLY_CYC_6, // 75 ms
    parameter int unsigned DLY7 = DLY_CYC_7  // 100 ms
)(
    input  wire logic               core_clk,       // 10 MHz clock
    input  wire logic               sys_rst,        // Async reset, high
    input  wire dpdc_reg_req_s      reg_req,        // Register request
    output logic [7:0]              reg_rdata,      // Read data
    input  wire logic [RAIL_N-1:0]  rail_enable,    // Rail enabled
    input  wire logic               rails_reg_pin,  // Grouped rails in reg
    input  wire logic               level_in_pin,   // Level shifter input
    input  wire dpdc_o3_mode_e      o3_mode,        // Output three usage
    input  wire logic               o3_ctrl_level,  // Software pin level
    input  wire logic               o3_vtt_use,     // Pin enables VTT LDO
    output logic [RAIL_N-1:0][2:0]  discharge_path, // One-hot 500/200/100
    output logic                    general_output_three, // Pin level
    output logic                    vtt_ldo_enable  // Termination enable
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Path enables: bit0 100 ohm, bit1 200 ohm, bit2 500 ohm
    function automatic logic [2:0] dis_decode(input logic [1:0] sel);
        case (sel)
            2'h1:    dis_decode = 3'h1;
            2'h2:    dis_decode = 3'h2;
            2'h3:    dis_decode = 3'h4;
            default: dis_decode = 3'h0;
        endcase
    endfunction

    localparam logic [CNT_W-1:0] DLY_TBL [8] = '{
        DLY0[CNT_W-1:0], DLY1[CNT_W-1:0], DLY2[CNT_W-1:0],
        DLY3[CNT_W-1:0], DLY4[CNT_W-1:0], DLY5[CNT_W-1:0],
        DLY6[CNT_W-1:0], DLY7[CNT_W-1:0]
    };

    logic [2*RAIL_N-1:0] fields;
    logic [2*RAIL_N-1:0] next_fields;
    logic [DLY_W-1:0]    dly_sel;
    logic [1:0]          reg_s1, reg_s2, reg_s3;
    logic [1:0]          sync_val;
    logic                timer_start;
    logic                pg_done;
    logic                wr_g2, wr_g3, wr_dly;

    assign wr_g2  = reg_req.wr && (reg_req.addr == OFS_DIS_GRP2);
    assign wr_g3  = reg_req.wr && (reg_req.addr == OFS_DIS_GRP3);
    assign wr_dly = reg_req.wr && (reg_req.addr == OFS_PG_DLY1);

    // ************************************************************
    // Discharge select fields
    // ************************************************************
    // Write first, then the enable override so hardware always wins
    always_comb begin
        next_fields = fields;
        if (wr_g2) begin
            next_fields[GRP3_LSB-1:0] = reg_req.wdata;
        end
        if (wr_g3) begin
            next_fields[GRP3_LSB +: GRP3_W] = reg_req.wdata[GRP3_W-1:0];
        end
        for (int i = 0; i < RAIL_N; i++) begin
            if (rail_enable[i]) begin
                next_fields[FIELD_W*i +: FIELD_W] = DIS_NONE;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fields <= DIS_RST;
        end else begin
            fields <= next_fields;
        end
    end

    // Decoded resistor path enables, registered
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            discharge_path <= '0;
        end else begin
            for (int i = 0; i < RAIL_N; i++) begin
                discharge_path[i] <= dis_decode(fields[FIELD_W*i +: FIELD_W]);
            end
        end
    end

    // ************************************************************
    // Delay select and read-back
    // ************************************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dly_sel <= DLY_RST;
        end else if (wr_dly) begin
            dly_sel <= reg_req.wdata[DLY_W-1:0];
        end
    end

    // Unmapped offsets read as zero; data holds until the next read
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_DIS_GRP2: reg_rdata <= fields[GRP3_LSB-1:0];
                OFS_DIS_GRP3: reg_rdata <= {2'h0, fields[GRP3_LSB +: GRP3_W]};
                OFS_PG_DLY1:  reg_rdata <= {5'h00, dly_sel};
                default:      reg_rdata <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Pin input synchronisers, accepted when stages two and three agree
    // ************************************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_s1   <= 2'h0;
            reg_s2   <= 2'h0;
            reg_s3   <= 2'h0;
            sync_val <= 2'h0;
        end else begin
            reg_s1 <= {level_in_pin, rails_reg_pin};
            reg_s2 <= reg_s1;
            reg_s3 <= reg_s2;
            for (int i = 0; i < 2; i++) begin
                if (reg_s2[i] == reg_s3[i]) begin
                    sync_val[i] <= reg_s3[i];
                end
            end
        end
    end

    // ************************************************************
    // Power-good delay and output three
    // ************************************************************
    // Timer idle when the pin is software-driven and not used for VTT
    always_comb begin
        timer_start = sync_val[0];
        if (o3_mode == O3_MODE_LS) begin
            timer_start = sync_val[0] && sync_val[1];
        end else if (o3_mode == O3_MODE_CTRL && !o3_vtt_use) begin
            timer_start = 1'b0;
        end
    end

    dpdc_pg_timer u_timer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .start    (timer_start),
        .target   (DLY_TBL[dly_sel]),
        .done     (pg_done)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            general_output_three <= 1'b0;
            vtt_ldo_enable       <= 1'b0;
        end else begin
            vtt_ldo_enable <= o3_vtt_use && pg_done;
            case (o3_mode)
                O3_MODE_PG:   general_output_three <= pg_done;
                O3_MODE_LS:   general_output_three <= pg_done;
                O3_MODE_CTRL: general_output_three <= o3_ctrl_level;
                default:      general_output_three <= 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [CNT_W-1:0] hold_cnt;

    // Cycles the start condition has held, for the delay check
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt <= '0;
        end else if (!timer_start) begin
            hold_cnt <= '0;
        end else if (hold_cnt != '1) begin
            hold_cnt <= hold_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_force_buck_five: assert property (
        rail_enable[RAIL_BUCK_FIVE] |=> fields[1:0] == DIS_NONE)
        else $error("enabled buck five field not forced");
    // Field clears one edge after enable, decoded path one edge later
    a_force_switch_b2: assert property (
        rail_enable[RAIL_SWITCH_B_TWO] |=> ##1
        discharge_path[RAIL_SWITCH_B_TWO] == 3'h0)
        else $error("enabled switch B2 still discharging");
    a_decode_path: assert property (
        fields[9:8] == 2'h3 |=> discharge_path[RAIL_AUX_LDO_THREE] == 3'h4)
        else $error("500 ohm code not decoded");
    a_group2_write: assert property (
        wr_g2 && rail_enable == '0 |=> fields[7:0] == $past(reg_req.wdata))
        else $error("group two write lost");
    a_group3_read: assert property (
        reg_req.rd && reg_req.addr == OFS_DIS_GRP3 && !wr_g3
        |=> reg_rdata == {2'h0, $past(fields[13:8])})
        else $error("group three read-back wrong");
    a_reserved_zero: assert property (
        reg_req.rd && reg_req.addr == OFS_PG_DLY1 |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved bits not zero");
    a_pg_needs_rails: assert property (
        $rose(pg_done) |-> $past(timer_start) && $past(sync_val[0]))
        else $error("power good without rails in regulation");
    a_delay_length: assert property (
        $rose(pg_done) |-> hold_cnt > DLY_TBL[$past(dly_sel)])
        else $error("power good delay too short");
    a_ctrl_mode_pin: assert property (
        o3_mode == O3_MODE_CTRL && !o3_vtt_use
        |=> general_output_three == $past(o3_ctrl_level) && !pg_done)
        else $error("software pin level not followed");

endmodule // dpdc_top
